// *** rsc_params.svh ***
// Constants of the reset source controller: offsets, fields, resets, timing
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define RSC_OFS_CAUSE 8'hEF
`define RSC_OFS_STAT 8'hF0
`define RSC_OFS_MASK 8'hF1

// ****************************************
// Cause register bit positions
// ****************************************
`define RSC_B_PIN 0
`define RSC_B_POR 1
`define RSC_B_LOSS 2
`define RSC_B_WDT 3
`define RSC_B_SW 4
`define RSC_B_CMP 5
`define RSC_B_FLASH 6
`define RSC_B_ONE 7

// ****************************************
// Reset values
// ****************************************
`define RSC_CAUSE_RST 7'h02
`define RSC_STAT_RST 8'h00
`define RSC_MASK_RST 8'h00
`define RSC_SYNC_RST 3'h3

// ****************************************
// Timing
// ****************************************
`define RSC_CLK_MHZ 250
`define RSC_LOSS_US 100
`define RSC_LOSS_CYC (`RSC_LOSS_US * `RSC_CLK_MHZ)
`define RSC_HOLD_CYC 5'h0F
`define RSC_WDT_DIV_LAST 4'hB

`endif

// *** rsc_pkg.sv ***
// Types shared by the reset source controller files
package rsc_pkg;
  // Top state: running, held by the pin, or holding an internal reset
  typedef enum logic [1:0] {RSC_RUN, RSC_PIN, RSC_HOLD} rsc_state_t;
  // Reset source chosen in one cycle
  typedef enum logic [2:0] {
    SRC_NONE, SRC_PIN, SRC_POR, SRC_LOSS, SRC_CMP, SRC_WDT, SRC_FLASH, SRC_SW
  } rsc_src_t;
endpackage : rsc_pkg

// *** rsc_flash_if.sv ***
// Flash access signals passed from the top to the flash fault checker
`timescale 1ns/1ns
interface rsc_flash_if;
  logic rd;          // Data read from code space
  logic wr;          // Write or erase attempt
  logic fetch;       // Instruction fetch
  logic [15:0] addr; // Target address
  logic [15:0] lock; // Lock byte address
  logic wen;         // Flash write enable
  logic sec;         // Blocked by security settings
  logic vmon_on;     // Supply monitor enabled
  logic vmon_high;   // Supply monitor at high threshold
  logic fault;       // Access is illegal
  modport req (output rd, wr, fetch, addr, lock, wen, sec, vmon_on, vmon_high, input fault);
  modport chk (input rd, wr, fetch, addr, lock, wen, sec, vmon_on, vmon_high, output fault);
endinterface : rsc_flash_if

// *** rsc_flash_check.sv ***
// Flash fault checker: flags illegal flash accesses in the same cycle
`timescale 1ns/1ns
module rsc_flash_check (
  rsc_flash_if.chk f
);
  // ****************************************
  // Fault terms
  // ****************************************
  logic wr_live; // Write or erase with write enable set
  logic above;   // Target beyond the lock byte
  assign wr_live = f.wr & f.wen;
  assign above = (f.addr > f.lock);
  // Any access above user space, a read or write blocked by security, or a write with unsafe supply
  assign f.fault = (above & (f.rd | wr_live | f.fetch))
                 | (f.sec & (f.rd | wr_live))
                 | (wr_live & (~f.vmon_on | ~f.vmon_high));
endmodule : rsc_flash_check

// *** rsc_loss_timer.sv ***
// Clock loss timer: counts held-clock cycles and fires after the limit
`timescale 1ns/1ns
module rsc_loss_timer #(
  parameter int LIMIT = 25000
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_arm,
  input wire logic i_stall,
  output logic o_fire
);
  // ****************************************
  // Stall counter
  // ****************************************
  logic [15:0] cnt_q; // Consecutive held cycles
  logic fire_q;       // Timeout pulse

  // Count while armed and held; any live clock cycle recharges it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 16'h0000;
      fire_q <= 1'b0;
    end else if (!i_arm || !i_stall) begin
      cnt_q <= 16'h0000;
      fire_q <= 1'b0;
    end else begin
      // Fire once the hold has lasted longer than the limit
      fire_q <= (cnt_q == LIMIT[15:0]);
      if (cnt_q != 16'hFFFF) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
  assign o_fire = fire_q;
endmodule : rsc_loss_timer

// *** rsc_top.sv ***
// Reset source controller: merges reset sources and records the cause
//
// What this block does
// - Pin low resets; pin flag set on exit
// - Clock held over 100 us resets
// - Clock loss flag marks only that reset
// - Clock loss bit write enables detector
// - Internal resets never drive the pin
// - Comparator bit enables source, reads cause
// - Enabled comparator low resets device
// - Watchdog restarts on system clock/12
// - Watchdog expiry resets, sets its flag
// - Flash access above lock byte resets
// - Security-blocked flash read or write resets
// - Flash write with weak supply resets
// - Flash flag marks only flash reset
`timescale 1ns/1ns
`include "rsc_params.svh"
module rsc_top #(
  parameter int LOSS_CYC = `RSC_LOSS_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rst_pin_n,
  input wire logic i_clk_stall,
  input wire logic i_cmp_out,
  input wire logic i_vmon_low,
  input wire logic i_vmon_on,
  input wire logic i_vmon_high,
  input wire logic i_wdt_expire,
  input wire logic i_flash_rd,
  input wire logic i_flash_wr,
  input wire logic i_fetch,
  input wire logic [15:0] i_flash_addr,
  input wire logic [15:0] i_lock_addr,
  input wire logic i_flash_wen,
  input wire logic i_sec_block,
  output logic o_sys_rst,
  output logic o_wdt_start,
  output logic o_wdt_tick,
  output logic o_irq
);
  // ****************************************
  // Declarations
  // ****************************************
  rsc_pkg::rsc_state_t state_q; // Top state
  rsc_pkg::rsc_src_t pick;      // Source chosen this cycle
  logic [4:0] hold_q;           // Internal reset hold count
  logic [2:0] s1_q;             // First sync stage: pin, comparator, low supply
  logic [2:0] s2_q;             // Second sync stage
  logic pin_s;                  // Pin level, high when released
  logic cmp_s;                  // Comparator output
  logic vlow_s;                 // Supply below threshold
  logic [6:0] cause_q;          // Cause of the latest reset
  logic cmp_en_q;               // Comparator as reset source
  logic loss_en_q;              // Clock loss detector enabled
  logic vmon_en_q;              // Supply monitor as reset source
  logic [7:0] stat_q;           // Sticky event status
  logic [7:0] mask_q;           // Interrupt mask
  logic [7:0] rdata_q;          // Read data
  logic [7:0] ev_vec;           // Cause bits of an event this cycle
  logic [3:0] div_q;            // Watchdog clock divider
  logic tick_q;                 // Divided watchdog tick
  logic start_q;                // Watchdog restart pulse
  logic loss_fire;              // Clock loss timeout
  logic sw_wr;                  // Software reset write
  logic cause_wr;               // Write to the cause register
  logic leave;                  // Last cycle of any reset
  logic running;                // No reset in progress

  rsc_flash_if fl ();

  // One-hot cause bits for a source
  function automatic logic [7:0] cause_vec(input rsc_pkg::rsc_src_t s);
    logic [7:0] v;
    v = 8'h00;
    case (s)
      rsc_pkg::SRC_PIN: v[`RSC_B_PIN] = 1'b1;
      rsc_pkg::SRC_POR: v[`RSC_B_POR] = 1'b1;
      rsc_pkg::SRC_LOSS: v[`RSC_B_LOSS] = 1'b1;
      rsc_pkg::SRC_CMP: v[`RSC_B_CMP] = 1'b1;
      rsc_pkg::SRC_WDT: v[`RSC_B_WDT] = 1'b1;
      rsc_pkg::SRC_FLASH: v[`RSC_B_FLASH] = 1'b1;
      rsc_pkg::SRC_SW: v[`RSC_B_SW] = 1'b1;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : cause_vec

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Pin is only sampled here; nothing in this block drives it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q <= `RSC_SYNC_RST;
      s2_q <= `RSC_SYNC_RST;
    end else begin
      s1_q <= {i_vmon_low, i_cmp_out, i_rst_pin_n};
      s2_q <= s1_q;
    end
  end
  assign pin_s = s2_q[0];
  assign cmp_s = s2_q[1];
  assign vlow_s = s2_q[2];

  // ****************************************
  // Sub-blocks
  // ****************************************
  assign running = (state_q == rsc_pkg::RSC_RUN);

  // Detector armed only while enabled and running
  rsc_loss_timer #(
    .LIMIT(LOSS_CYC)
  ) u_loss (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_arm(loss_en_q & running),
    .i_stall(i_clk_stall),
    .o_fire(loss_fire)
  );

  assign fl.rd = i_flash_rd;
  assign fl.wr = i_flash_wr;
  assign fl.fetch = i_fetch;
  assign fl.addr = i_flash_addr;
  assign fl.lock = i_lock_addr;
  assign fl.wen = i_flash_wen;
  assign fl.sec = i_sec_block;
  assign fl.vmon_on = i_vmon_on;
  assign fl.vmon_high = i_vmon_high;

  rsc_flash_check u_flash (
    .f(fl)
  );

  // ****************************************
  // Source selection
  // ****************************************
  assign cause_wr = i_wr && (i_addr == `RSC_OFS_CAUSE);
  assign sw_wr = cause_wr && i_wdata[`RSC_B_SW];

  // Fixed priority when several sources fire together
  always_comb begin
    if (!pin_s) begin
      pick = rsc_pkg::SRC_PIN;
    end else if (vmon_en_q && vlow_s) begin
      pick = rsc_pkg::SRC_POR;
    end else if (loss_en_q && loss_fire) begin
      pick = rsc_pkg::SRC_LOSS;
    end else if (cmp_en_q && !cmp_s) begin
      pick = rsc_pkg::SRC_CMP;
    end else if (i_wdt_expire) begin
      pick = rsc_pkg::SRC_WDT;
    end else if (fl.fault) begin
      pick = rsc_pkg::SRC_FLASH;
    end else if (sw_wr) begin
      pick = rsc_pkg::SRC_SW;
    end else begin
      pick = rsc_pkg::SRC_NONE;
    end
  end

  // Pin cause is logged on exit, others on entry
  always_comb begin
    ev_vec = 8'h00;
    if (state_q == rsc_pkg::RSC_PIN && pin_s) begin
      ev_vec = cause_vec(rsc_pkg::SRC_PIN);
    end else if (running && pick != rsc_pkg::SRC_PIN) begin
      ev_vec = cause_vec(pick);
    end
  end

  assign leave = pin_s && ((state_q == rsc_pkg::RSC_PIN)
               || (state_q == rsc_pkg::RSC_HOLD && hold_q == 5'h00));

  // ****************************************
  // Reset state machine
  // ****************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= rsc_pkg::RSC_RUN;
      hold_q <= 5'h00;
    end else begin
      case (state_q)
        // Wait for a source
        rsc_pkg::RSC_RUN: begin
          if (pick == rsc_pkg::SRC_PIN) begin
            state_q <= rsc_pkg::RSC_PIN;
          end else if (pick != rsc_pkg::SRC_NONE) begin
            state_q <= rsc_pkg::RSC_HOLD;
            hold_q <= `RSC_HOLD_CYC;
          end
        end
        // Held for as long as the pin stays low
        rsc_pkg::RSC_PIN: begin
          if (pin_s) begin
            state_q <= rsc_pkg::RSC_RUN;
          end
        end
        // Internal reset of fixed length; pin low takes over
        rsc_pkg::RSC_HOLD: begin
          if (!pin_s) begin
            state_q <= rsc_pkg::RSC_PIN;
          end else if (hold_q == 5'h00) begin
            state_q <= rsc_pkg::RSC_RUN;
          end else begin
            hold_q <= hold_q - 5'h01;
          end
        end
        default: begin
          state_q <= rsc_pkg::RSC_RUN;
        end
      endcase
    end
  end
  assign o_sys_rst = !running;

  // ****************************************
  // Cause register
  // ****************************************
  // Whole field replaced so only the latest source shows
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cause_q <= `RSC_CAUSE_RST;
    end else if (ev_vec != 8'h00) begin
      cause_q <= ev_vec[6:0];
    end
  end

  // Source enables: cleared by power-on, loaded by writes
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmp_en_q <= 1'b0;
      loss_en_q <= 1'b0;
      vmon_en_q <= 1'b0;
    end else if (running && pick != rsc_pkg::SRC_NONE) begin
      // Any reset drops comparator and clock loss sources
      cmp_en_q <= 1'b0;
      loss_en_q <= 1'b0;
    end else if (running && cause_wr) begin
      cmp_en_q <= i_wdata[`RSC_B_CMP];
      loss_en_q <= i_wdata[`RSC_B_LOSS];
      vmon_en_q <= i_wdata[`RSC_B_POR];
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // Event set wins over a write-one clear in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stat_q <= `RSC_STAT_RST;
    end else if (i_wr && i_addr == `RSC_OFS_STAT) begin
      stat_q <= (stat_q & ~i_wdata) | ev_vec;
    end else begin
      stat_q <= stat_q | ev_vec;
    end
  end

  // Mask register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mask_q <= `RSC_MASK_RST;
    end else if (i_wr && i_addr == `RSC_OFS_MASK) begin
      mask_q <= i_wdata;
    end
  end
  assign o_irq = |(stat_q & mask_q);

  // ****************************************
  // Read port
  // ****************************************
  // Data stand only in the cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        // Top bit always reads one
        `RSC_OFS_CAUSE: rdata_q <= {1'b1, cause_q};
        `RSC_OFS_STAT: rdata_q <= stat_q;
        `RSC_OFS_MASK: rdata_q <= mask_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign o_rdata = rdata_q;

  // ****************************************
  // Watchdog restart and clock
  // ****************************************
  // Divide by twelve, restarted by every reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_q <= 4'h0;
      tick_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= leave;
      // Also cleared on the edge that enters reset, so no tick shows inside it
      if (!running || pick != rsc_pkg::SRC_NONE) begin
        div_q <= 4'h0;
        tick_q <= 1'b0;
      end else begin
        tick_q <= (div_q == `RSC_WDT_DIV_LAST);
        div_q <= (div_q == `RSC_WDT_DIV_LAST) ? 4'h0 : div_q + 4'h1;
      end
    end
  end
  assign o_wdt_start = start_q;
  assign o_wdt_tick = tick_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_pin;
    (running && !pin_s) |=> state_q == rsc_pkg::RSC_PIN ##1 1'b1;
  endproperty
  a_pin: assert property (p_pin) else $error("pin low not taken");

  property p_pin_flag;
    (state_q == rsc_pkg::RSC_PIN && pin_s) |=> running && cause_q == 7'h01;
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag wrong");

  property p_loss;
    (running && pick == rsc_pkg::SRC_LOSS) |=> o_sys_rst && cause_q == 7'h04;
  endproperty
  a_loss: assert property (p_loss) else $error("clock loss reset wrong");

  property p_cmp;
    (running && pin_s && !vlow_s && !loss_fire && cmp_en_q && !cmp_s)
      |=> cause_q == 7'h20;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator reset wrong");

  property p_wdt;
    (running && pick == rsc_pkg::SRC_WDT) |=> cause_q == 7'h08 && !o_wdt_tick;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset wrong");

  property p_flash;
    (running && pick == rsc_pkg::SRC_FLASH) |=> cause_q == 7'h40 ##1 o_sys_rst;
  endproperty
  a_flash: assert property (p_flash) else $error("flash reset wrong");

  property p_hold;
    (running ##1 state_q == rsc_pkg::RSC_HOLD) |-> o_sys_rst [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("reset too short");

  property p_onehot;
    (state_q == rsc_pkg::RSC_HOLD) |-> $onehot(cause_q);
  endproperty
  a_onehot: assert property (p_onehot) else $error("cause not one-hot");

  property p_restart;
    leave |=> o_wdt_start ##[1:12] (o_wdt_tick || o_sys_rst);
  endproperty
  a_restart: assert property (p_restart) else $error("watchdog not restarted");

  property p_enable;
    (running && pick == rsc_pkg::SRC_NONE && cause_wr) |=> loss_en_q == $past(i_wdata[2]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable not stored");

  c_sw: cover property (running && pick == rsc_pkg::SRC_SW ##1 o_sys_rst);
  c_pin: cover property (state_q == rsc_pkg::RSC_PIN ##1 running);
  c_irq: cover property ($rose(o_irq));
endmodule : rsc_top

// *** rsc_src_model.sv ***
// Far-side model: reset pin circuit, comparator, supply monitor and watchdog
`timescale 1ns/1ns
module rsc_src_model (
  input wire logic i_clk,
  output logic o_rst_pin_n,
  output logic o_cmp_out,
  output logic o_vmon_low,
  output logic o_dog_expire
);
  // ****************************************
  // Idle levels
  // ****************************************
  initial begin
    o_rst_pin_n = 1'b1; // Pull-up holds the pin high while nobody pulls it
    o_cmp_out = 1'b1; // Comparator already settled before any enable
    o_vmon_low = 1'b0; // Supply good
    o_dog_expire = 1'b0; // Watchdog serviced
  end

  // ****************************************
  // Stimulus tasks
  // ****************************************
  // Pull the pin low for n cycles, then the pull-up returns it high
  task automatic pull_pin(input int n);
    @(posedge i_clk);
    o_rst_pin_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_rst_pin_n <= 1'b1;
  endtask : pull_pin

  // Move the comparator output to a new settled level
  task automatic set_cmp(input logic v);
    @(posedge i_clk);
    o_cmp_out <= v;
  endtask : set_cmp

  // Supply drops below threshold for n cycles
  task automatic dip_supply(input int n);
    @(posedge i_clk);
    o_vmon_low <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_vmon_low <= 1'b0;
  endtask : dip_supply

  // Watchdog runs out once, for one cycle
  task automatic expire;
    @(posedge i_clk);
    o_dog_expire <= 1'b1;
    @(posedge i_clk);
    o_dog_expire <= 1'b0;
  endtask : expire
endmodule : rsc_src_model

// *** rsc_top_bench.sv ***
// Self-checking testbench of the reset source controller
`timescale 1ns/1ns
`include "rsc_params.svh"
module rsc_top_bench;
  localparam int LOSS = 20; // Short clock loss limit for simulation
  logic i_clk;
  logic i_resetn;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rdata;
  logic pin_n;
  logic stall;
  logic cmp;
  logic vlow;
  logic von;
  logic vhigh;
  logic dog;
  logic frd;
  logic fwr;
  logic ffetch;
  logic [15:0] faddr;
  logic [15:0] lock;
  logic fwen;
  logic fsec;
  logic o_sys_rst;
  logic o_wdt_start;
  logic o_wdt_tick;
  logic o_irq;
  int errors;
  int checked;
  int cyc;
  int i;
  // Flash fault cases: {rd, wr, fetch, wen, sec, monitor on, monitor high, address}
  logic [22:0] fcase [6] = '{{7'b1000011, 16'h1000}, {7'b0101011, 16'h1000},
    {7'b0010011, 16'h1000}, {7'b1000111, 16'h0100}, {7'b0101001, 16'h0100},
    {7'b0101010, 16'h0100}};

  rsc_top #(.LOSS_CYC(LOSS)) u_rsc_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rst_pin_n(pin_n),
    .i_clk_stall(stall), .i_cmp_out(cmp), .i_vmon_low(vlow), .i_vmon_on(von),
    .i_vmon_high(vhigh), .i_wdt_expire(dog), .i_flash_rd(frd), .i_flash_wr(fwr),
    .i_fetch(ffetch), .i_flash_addr(faddr), .i_lock_addr(lock), .i_flash_wen(fwen),
    .i_sec_block(fsec), .o_sys_rst(o_sys_rst), .o_wdt_start(o_wdt_start),
    .o_wdt_tick(o_wdt_tick), .o_irq(o_irq));

  rsc_src_model u_rsc_src_model (.i_clk(i_clk), .o_rst_pin_n(pin_n), .o_cmp_out(cmp),
    .o_vmon_low(vlow), .o_dog_expire(dog));

  // ****************************************
  // Clock and timeout
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // Cut a hang short well past the expected run length
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // One-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : reg_wr
  // Read, then compare the data of the following cycle
  task automatic check_rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check(o_rdata, exp, msg);
  endtask : check_rd
  // Wait for a system reset and its end; len 0 skips the hold length
  task automatic wait_rst(input int len);
    int k;
    int n;
    k = 0;
    n = 0;
    #1;
    while (o_sys_rst !== 1'b1 && k < 200) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    while (o_sys_rst === 1'b1 && n < 200) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check({7'h00, k < 200}, 8'h01, "reset seen");
    if (len > 0) check(8'(n), 8'(len), "hold length");
  endtask : wait_rst
  // No reset may appear for n cycles
  task automatic quiet(input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(posedge i_clk);
      #1;
      if (o_sys_rst !== 1'b0) hit = 1'b1;
    end
    check({7'h00, hit}, 8'h00, "unexpected reset");
  endtask : quiet
  // One flash access for one cycle, then idle
  task automatic flash_op(input logic [22:0] c);
    @(posedge i_clk);
    {frd, fwr, ffetch, fwen, fsec, von, vhigh, faddr} <= c;
    @(posedge i_clk);
    {frd, fwr, ffetch, fwen, fsec, von, vhigh, faddr} <= {7'b0000011, 16'h0000};
  endtask : flash_op
  // Closing report
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {errors, checked, cyc} = '0;
    {i_resetn, i_wr, i_rd, i_addr, i_wdata, stall} = '0;
    {frd, fwr, ffetch, fwen, fsec, von, vhigh, faddr} = {7'b0000011, 16'h0000};
    lock = 16'h0FFF;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    // Power-on state and register map
    check_rd(`RSC_OFS_CAUSE, 8'h82, "power-on cause");
    check_rd(`RSC_OFS_STAT, 8'h00, "status reset");
    check_rd(`RSC_OFS_MASK, 8'h00, "mask reset");
    reg_wr(8'h10, 8'h55);
    check_rd(8'h10, 8'h00, "unmapped read");
    check_rd(`RSC_OFS_MASK, 8'h00, "mask after unmapped write");
    $display("test power-on done");
    // Software reset, then watchdog restart and its divided clock
    reg_wr(`RSC_OFS_CAUSE, 8'h12);
    wait_rst(16);
    check({7'h00, o_wdt_start}, 8'h01, "watchdog start");
    i = 0;
    while (o_wdt_tick !== 1'b1 && i < 20) begin
      @(posedge i_clk);
      #1;
      i++;
    end
    check(8'(i), 8'h0C, "watchdog tick spacing");
    check_rd(`RSC_OFS_CAUSE, 8'h90, "software cause");
    reg_wr(`RSC_OFS_CAUSE, 8'h00);
    quiet(8);
    $display("test software reset done");
    // Interrupt: sticky status, mask, write-one clear
    check_rd(`RSC_OFS_STAT, 8'h10, "status after software reset");
    check({7'h00, o_irq}, 8'h00, "masked interrupt");
    reg_wr(`RSC_OFS_MASK, 8'h10);
    #1;
    check({7'h00, o_irq}, 8'h01, "unmasked interrupt");
    reg_wr(`RSC_OFS_STAT, 8'h10);
    #1;
    check({7'h00, o_irq}, 8'h00, "interrupt cleared");
    check_rd(`RSC_OFS_STAT, 8'h00, "status cleared");
    $display("test interrupt done");
    // Pin reset
    fork
      u_rsc_src_model.pull_pin(6);
      wait_rst(0);
    join
    check_rd(`RSC_OFS_CAUSE, 8'h81, "pin cause");
    $display("test pin reset done");
    // Clock loss: disabled first, then enabled with the boundary count
    stall <= 1'b1;
    quiet(LOSS + 20);
    stall <= 1'b0;
    reg_wr(`RSC_OFS_CAUSE, 8'h04);
    stall <= 1'b1;
    quiet(LOSS);
    wait_rst(16);
    stall <= 1'b0;
    check_rd(`RSC_OFS_CAUSE, 8'h84, "clock loss cause");
    $display("test clock loss done");
    // Comparator: ignored until enabled
    u_rsc_src_model.set_cmp(1'b0);
    quiet(10);
    reg_wr(`RSC_OFS_CAUSE, 8'h20);
    wait_rst(16);
    u_rsc_src_model.set_cmp(1'b1);
    check_rd(`RSC_OFS_CAUSE, 8'hA0, "comparator cause");
    $display("test comparator done");
    // Watchdog expiry
    fork
      u_rsc_src_model.expire();
      wait_rst(16);
    join
    check_rd(`RSC_OFS_CAUSE, 8'h88, "watchdog cause");
    $display("test watchdog done");
    // Flash: a legal write at the lock byte, then every fault kind except a security-blocked write
    flash_op({7'b0101011, 16'h0FFF});
    quiet(5);
    for (i = 0; i < 6; i++) begin
      flash_op(fcase[i]);
      wait_rst(16);
      check_rd(`RSC_OFS_CAUSE, 8'hC0, "flash cause");
    end
    $display("test flash done");
    // Supply monitor as a reset source
    reg_wr(`RSC_OFS_CAUSE, 8'h02);
    fork
      u_rsc_src_model.dip_supply(6);
      wait_rst(16);
    join
    check_rd(`RSC_OFS_CAUSE, 8'h82, "supply cause");
    $display("test supply done");
    stop_test();
  end
endmodule : rsc_top_bench
